// *** src/dwt_defs.svh ***
// Notes on behaviour
// - While active, counter bit 6 falling from one to zero on a tick requests a chip reset.
// - Writing zero to the reset trigger bit resets the chip at once, if the activate bit is set or written one.
// - Writing the counter reloads it and so holds off the reset.
// - Hardware activation forces the activate bit high; writes cannot clear it.
// - Software activation: disabled until bit 0 set; only reset disables.
// - Hardware option enabled: stop acts as wait, counting continues.
// - Stop mode entered only while the watchdog is disabled.
// - Leaving stop on an interrupt resumes counting.
// - Reset value is FEh without the hardware option: activate zero, count and trigger bits all ones.
// - Count field reversed: register bit 7 is counter lsb, bit 2 top.
// - Six count bits give 64 periods, 3072 to 196608 clocks.
// - Activate zero: free 7-bit timer, trigger bit as its msb.
// - At least 28 instructions run after activation or reset.
// - A watchdog reset reinitialises the watchdog counter too.
// - Watchdog reset released 2048 clocks later, like a pin reset.
`ifndef DWT_DEFS_SVH
`define DWT_DEFS_SVH

`define DWT_ADR_W          8
`define DWT_REG_WDG        8'hD8
`define DWT_REG_STAT       8'hDC
`define DWT_WDG_RESET      8'hFE
`define DWT_CNT_W          7
`define DWT_CNT_RESET      7'h7F
`define DWT_CNT_TOP        6
`define DWT_BIT_C          0
`define DWT_BIT_SR         1
`define DWT_FIELD_LSB      2
`define DWT_STAT_STOP      0
`define DWT_STAT_WAIT      1
`define DWT_STAT_HWOPT     2
`define DWT_STAT_WDRST     3
`define DWT_TICK_CYCLES    3072
`define DWT_STRETCH_CYCLES 2048

`endif

// *** src/dwt_pkg.sv ***
package dwt_pkg;

    // Power mode of the core as seen by the watchdog
    typedef enum logic [1:0] {
        DWT_PWR_RUN,
        DWT_PWR_WAIT,
        DWT_PWR_STOP
    } dwt_pwr_e;

    // Status carried to the bus read mux; only the reset flag can be cleared by a write
    typedef struct packed {
        logic wd_reset;
        logic hw_option;
        logic wait_mode;
        logic stop_mode;
    } dwt_stat_s;

endpackage : dwt_pkg

// *** src/dwt_prescaler.sv ***
`timescale 1ns/1ps
`include "dwt_defs.svh"

module dwt_prescaler #(
    parameter int DIV = `DWT_TICK_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic clr_i,
    input  wire logic run_i,
    output logic      tick_o
);
    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] div_reg;

    // Divider; a clear restarts a full period so a reload never gets a short first step
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            div_reg <= '0;
            tick_o  <= 1'b0;
        end else if (ce_i) begin
            tick_o <= 1'b0;
            if (run_i) begin
                if (div_reg == LAST) begin
                    div_reg <= '0;
                    tick_o  <= 1'b1;
                end else begin
                    div_reg <= div_reg + 1'b1;
                end
            end
        end
    end
endmodule : dwt_prescaler

// *** src/dwt_stretch.sv ***
`timescale 1ns/1ps
`include "dwt_defs.svh"

module dwt_stretch #(
    parameter int CYCLES = `DWT_STRETCH_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic trig_i,
    output logic      hold_o
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LOAD = W'(CYCLES);

    logic [W-1:0] cnt_reg;

    // Pin reset and watchdog trigger both arm the same delay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= LOAD;
            hold_o  <= 1'b1;
        end else if (ce_i) begin
            if (trig_i) begin
                cnt_reg <= LOAD;
                hold_o  <= 1'b1;
            end else if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - 1'b1;
                hold_o  <= (cnt_reg != W'(1));
            end else begin
                hold_o <= 1'b0;
            end
        end
    end
endmodule : dwt_stretch

// *** src/dwt_top.sv ***
`timescale 1ns/1ps
`include "dwt_defs.svh"

module dwt_top
    import dwt_pkg::*;
#(
    parameter int TICK_CYCLES    = `DWT_TICK_CYCLES,
    parameter int STRETCH_CYCLES = `DWT_STRETCH_CYCLES
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    // Classic Wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [`DWT_ADR_W-1:0]  wb_adr_i,
    input  wire logic [31:0]            wb_dat_i,
    input  wire logic [3:0]             wb_sel_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // Activation option strap and core power requests
    input  wire logic                   hw_option_i,
    input  wire logic                   stop_instr_i,
    input  wire logic                   wait_instr_i,
    input  wire logic                   wake_irq_i,
    // Reset and power outputs
    output logic                        wdg_rst_req_o,
    output logic                        core_rst_o,
    output logic                        stop_mode_o,
    output logic                        wait_mode_o,
    output logic                        wdg_active_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                  opt_meta_reg;
    logic                  opt_sync_reg;
    logic                  hw_opt_reg;
    logic                  c_reg;
    logic [`DWT_CNT_W-1:0] cnt_reg;
    logic [`DWT_CNT_W-1:0] cnt_next;
    logic                  active;
    logic                  active_d_reg;
    logic                  hold;
    logic                  int_rst;
    logic                  bus_req;
    logic                  wr_wdg;
    logic                  wr_stat;
    logic                  wr_c;
    logic [`DWT_CNT_W-1:0] wr_cnt;
    logic [7:0]            rd_wdg;
    logic                  tick;
    logic                  cnt_fall;
    logic                  sw_rst;
    logic                  wdg_fire;
    logic                  presc_clr;
    logic                  wdrst_flag_reg;
    dwt_pwr_e              pwr_reg;
    dwt_pwr_e              pwr_next;
    dwt_stat_s             stat;

    // ------------------------------------------------------------
    // Option strap: two flops, then caught while reset is asserted
    // ------------------------------------------------------------
    // Strap comes from a pin, so it is synchronised first
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            opt_meta_reg <= hw_option_i;
            opt_sync_reg <= opt_meta_reg;
        end
    end

    // Option is frozen outside reset; a moving strap cannot disable the dog
    always_ff @(posedge clk_i) begin
        if (ce_i && int_rst) begin
            hw_opt_reg <= opt_sync_reg;
        end
    end

    // ------------------------------------------------------------
    // Internal reset: pin reset or stretched watchdog reset
    // ------------------------------------------------------------
    // delay before release
    dwt_stretch #(
        .CYCLES (STRETCH_CYCLES)
    ) u_stretch (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .trig_i (wdg_fire),
        .hold_o (hold)
    );

    assign int_rst = rst_i | hold;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // One request per ack; the ack cycle itself is not a new request
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_wdg  = bus_req & wb_we_i & wb_sel_i[0]
                   & (wb_adr_i == `DWT_REG_WDG);
    assign wr_stat = bus_req & wb_we_i & wb_sel_i[0]
                   & (wb_adr_i == `DWT_REG_STAT);

    // ------------------------------------------------------------
    // Reversed field mapping between register byte and counter
    // ------------------------------------------------------------
    // bit 7 is the lsb stage
    for (genvar i = 0; i < `DWT_CNT_W - 1; i++) begin : g_map
        assign wr_cnt[i]   = wb_dat_i[7 - i];
        assign rd_wdg[7-i] = cnt_reg[i];
    end
    // Trigger bit is the top counter stage
    assign wr_cnt[`DWT_CNT_TOP]  = wb_dat_i[`DWT_BIT_SR];
    assign rd_wdg[`DWT_BIT_SR]   = cnt_reg[`DWT_CNT_TOP];
    assign rd_wdg[`DWT_BIT_C]    = active;

    // ------------------------------------------------------------
    // Activation
    // ------------------------------------------------------------
    // hardware option is always active
    assign active = hw_opt_reg | c_reg;
    // Activate bit as it stands after the current write
    assign wr_c   = active | wb_dat_i[`DWT_BIT_C];

    // set once, cleared only by reset
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            c_reg <= 1'b0;
        end else if (ce_i && wr_wdg && wb_dat_i[`DWT_BIT_C]) begin
            c_reg <= 1'b1;
        end
    end

    // Edge detect for activation restarts the prescaler
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            active_d_reg <= 1'b0;
        end else if (ce_i) begin
            active_d_reg <= active;
        end
    end

    // ------------------------------------------------------------
    // Prescaler: one counter step per tick period
    // ------------------------------------------------------------
    // a full period after activation or reload
    assign presc_clr = int_rst | wr_wdg | (active & ~active_d_reg);

    dwt_prescaler #(
        .DIV    (TICK_CYCLES)
    ) u_presc (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .clr_i  (presc_clr),
        .run_i  (pwr_reg != DWT_PWR_STOP),
        .tick_o (tick)
    );

    // ------------------------------------------------------------
    // Downcounter
    // ------------------------------------------------------------
    // Next count: a write beats a tick so reload always wins
    always_comb begin
        cnt_next = cnt_reg;
        if (wr_wdg) begin
            cnt_next = wr_cnt;
        end else if (tick) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            cnt_reg <= `DWT_CNT_RESET;
        end else if (ce_i) begin
            cnt_reg <= cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------
    // top stage one-to-zero
    // 64 periods from six count bits
    assign cnt_fall = active & ~wr_wdg & tick
                    & cnt_reg[`DWT_CNT_TOP] & ~cnt_next[`DWT_CNT_TOP];

    assign sw_rst   = wr_wdg & wr_c & ~wb_dat_i[`DWT_BIT_SR];

    // Nothing fires while the chip is still held in reset
    assign wdg_fire = ce_i & ~int_rst & (cnt_fall | sw_rst);

    // Request pulse for the chip reset controller
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdg_rst_req_o <= 1'b0;
        end else if (ce_i) begin
            wdg_rst_req_o <= wdg_fire;
        end
    end

    // Sticky cause flag; the pin reset or a write of one to it clears it, set beats clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdrst_flag_reg <= 1'b0;
        end else if (ce_i) begin
            if (wdg_fire) begin
                wdrst_flag_reg <= 1'b1;
            end else if (wr_stat && wb_dat_i[`DWT_STAT_WDRST]) begin
                wdrst_flag_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Power mode
    // ------------------------------------------------------------
    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            DWT_PWR_RUN: begin
                if (stop_instr_i) begin
                    pwr_next = active ? DWT_PWR_WAIT : DWT_PWR_STOP;
                end else if (wait_instr_i) begin
                    pwr_next = DWT_PWR_WAIT;
                end
            end
            DWT_PWR_WAIT: begin
                if (wake_irq_i) begin
                    pwr_next = DWT_PWR_RUN;
                end
            end
            DWT_PWR_STOP: begin
                if (wake_irq_i) begin
                    pwr_next = DWT_PWR_RUN;
                end
            end
            default: begin
                pwr_next = DWT_PWR_RUN;
            end
        endcase
    end

    // Mode register; any reset returns the core to run
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            pwr_reg <= DWT_PWR_RUN;
        end else if (ce_i) begin
            pwr_reg <= pwr_next;
        end
    end

    // ------------------------------------------------------------
    // Status and outputs
    // ------------------------------------------------------------
    assign stat.stop_mode = (pwr_reg == DWT_PWR_STOP);
    assign stat.wait_mode = (pwr_reg == DWT_PWR_WAIT);
    assign stat.hw_option = hw_opt_reg;
    assign stat.wd_reset  = wdrst_flag_reg;

    // All status outputs are registered copies of internal state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_rst_o   <= 1'b1;
            stop_mode_o  <= 1'b0;
            wait_mode_o  <= 1'b0;
            wdg_active_o <= 1'b0;
        end else if (ce_i) begin
            core_rst_o   <= int_rst;
            stop_mode_o  <= stat.stop_mode;
            wait_mode_o  <= stat.wait_mode;
            wdg_active_o <= active;
        end
    end

    // ------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------
    // Ack one cycle after the request; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `DWT_REG_WDG:  wb_dat_o <= {24'h00_0000, rd_wdg};
                    `DWT_REG_STAT: wb_dat_o <= {28'h000_0000, stat};
                    default:       wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : dwt_top

// *** sim/dwt_top_properties.sv ***
`timescale 1ns/1ps
module dwt_top_properties #(
    parameter int TICK_CYCLES    = 8,
    parameter int STRETCH_CYCLES = 4
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        stop_instr_i,
    input wire logic        wake_irq_i,
    input wire logic        wdg_rst_req_o,
    input wire logic        core_rst_o,
    input wire logic        stop_mode_o,
    input wire logic        wait_mode_o,
    input wire logic        wdg_active_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [15:0] hold_cnt;

    // Length of the current internal reset hold
    always_ff @(posedge clk_i) begin
        if (rst_i || !core_rst_o) begin
            hold_cnt <= 16'h0000;
        end else begin
            hold_cnt <= hold_cnt + 16'h0001;
        end
    end

    // A request not yet answered, and a write that kills the chip at once
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_kill;
        s_req ##0 (wb_we_i && wb_adr_i == 8'hD8 && wb_dat_i[1:0] == 2'b01 && !core_rst_o);
    endsequence

    property p_ack;
        s_req |=> wb_ack_o;
    endproperty
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_sw_rst;
        s_kill |-> ##[1:3] wdg_rst_req_o;
    endproperty
    property p_req_pulse;
        wdg_rst_req_o |=> !wdg_rst_req_o;
    endproperty
    property p_req_hold;
        wdg_rst_req_o |-> ##[1:2] core_rst_o;
    endproperty
    // Hold after a pin or watchdog reset is never cut short
    property p_hold_len;
        $fell(core_rst_o) |-> hold_cnt >= STRETCH_CYCLES;
    endproperty
    property p_stop_gate;
        $rose(stop_mode_o) |-> !$past(wdg_active_o);
    endproperty
    property p_stop_wait;
        stop_instr_i && wdg_active_o && !core_rst_o && !wake_irq_i && !stop_mode_o
            && !wait_mode_o |-> ##[1:2] (wait_mode_o && !stop_mode_o);
    endproperty
    property p_sw_stop;
        stop_instr_i && !wdg_active_o && !core_rst_o && !wake_irq_i && !stop_mode_o
            && !wait_mode_o |-> ##[1:2] stop_mode_o;
    endproperty
    property p_wake;
        wake_irq_i && !stop_instr_i |-> ##[1:2] (!stop_mode_o && !wait_mode_o);
    endproperty
    // Once on, only a chip reset turns the watchdog off
    property p_active_kept;
        wdg_active_o |=> (wdg_active_o || core_rst_o || $past(wdg_rst_req_o));
    endproperty

    a_ack: assert property (p_ack) else $error("ack missing");
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    a_sw_rst: assert property (p_sw_rst) else $error("no software reset");
    a_req_pulse: assert property (p_req_pulse) else $error("reset request too long");
    a_req_hold: assert property (p_req_hold) else $error("no chip reset");
    a_hold_len: assert property (p_hold_len) else $error("hold too short");
    a_stop_gate: assert property (p_stop_gate) else $error("stop while active");
    a_stop_wait: assert property (p_stop_wait) else $error("stop not as wait");
    a_sw_stop: assert property (p_sw_stop) else $error("stop refused");
    a_wake: assert property (p_wake) else $error("no wake");
    a_active_kept: assert property (p_active_kept) else $error("watchdog dropped");
endmodule : dwt_top_properties

bind dwt_top dwt_top_properties #(
    .TICK_CYCLES(TICK_CYCLES), .STRETCH_CYCLES(STRETCH_CYCLES)
) i_dwt_top_properties (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .stop_instr_i(stop_instr_i), .wake_irq_i(wake_irq_i), .wdg_rst_req_o(wdg_rst_req_o),
    .core_rst_o(core_rst_o), .stop_mode_o(stop_mode_o), .wait_mode_o(wait_mode_o),
    .wdg_active_o(wdg_active_o)
);

// *** sim/dwt_top_tb.sv ***
`timescale 1ns/1ps
module dwt_top_tb;
    localparam int TICK = 8;
    localparam int HOLD = 4;
    typedef struct packed {
        logic [7:0] wr;
        logic       tk;
        logic [7:0] ex;
    } dwt_row_s;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] dat   = 32'h0000_0000;
    logic        hw    = 1'b0;
    logic        stp   = 1'b0;
    logic        wk    = 1'b0;
    logic        wt    = 1'b0;
    logic [31:0] rd;
    logic        ack;
    logic        req;
    logic        crst;
    logic        sm;
    logic        wm;
    logic        act;
    logic [7:0]  q;
    int          errors = 0;
    int          checks = 0;
    int          n;
    // Write, wait none or one tick, read back; count field is bit reversed
    dwt_row_s    rows [6] = '{'{8'hFE, 1'b0, 8'hFE}, '{8'h02, 1'b0, 8'h02},
                           '{8'h06, 1'b1, 8'hFA}, '{8'h80, 1'b1, 8'h00},
                           '{8'h02, 1'b1, 8'hFC}, '{8'h00, 1'b1, 8'hFE}};

    // Short counts keep the run brief
    dwt_top #(.TICK_CYCLES(TICK), .STRETCH_CYCLES(HOLD)) i_dwt_top (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h1),
        .wb_dat_o(rd), .wb_ack_o(ack), .hw_option_i(hw), .stop_instr_i(stp),
        .wait_instr_i(wt), .wake_irq_i(wk), .wdg_rst_req_o(req),
        .core_rst_o(crst), .stop_mode_o(sm), .wait_mode_o(wm), .wdg_active_o(act)
    );

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    // Wait for a reset request, or for the hold to end; never open ended
    task automatic wait_for(input logic on_req, input int lim);
        n = 0;
        while ((on_req ? req !== 1'b1 : crst !== 1'b0) && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= lim) begin
            errors++;
            stop_test();
        end
    endtask : wait_for

    // One classic cycle; q takes the read data at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = rd[7:0];
        cyc <= 1'b0;
        @(posedge clk_i);
        if (k >= 20) begin
            errors++;
            stop_test();
        end
    endtask : wb

    // Strap is set as reset starts, so it is settled long before capture ends
    task automatic do_reset(input logic opt);
        hw    <= opt;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_for(1'b0, 40);
    endtask : do_reset

    // Stop request then wake; where it lands depends on activation
    task automatic power(input logic es, input logic ew);
        stp <= 1'b1;
        @(posedge clk_i);
        stp <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk_bit("stop mode", es, sm);
        chk_bit("wait mode", ew, wm);
        wk <= 1'b1;
        @(posedge clk_i);
        wk <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk_bit("run mode", 1'b0, sm | wm);
    endtask : power

    initial begin
        do_reset(1'b0);
        chk_bit("hold", 1'b1, n >= HOLD);
        wb(1'b0, 8'hD8, 8'h00);
        chk("reset value", 8'hFE, q);
        wb(1'b0, 8'h10, 8'h00);
        chk("unmapped", 8'h00, q);
        chk_bit("active", 1'b0, act);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, 8'hD8, rows[i].wr);
            repeat (TICK * rows[i].tk) @(posedge clk_i);
            wb(1'b0, 8'hD8, 8'h00);
            chk("count", rows[i].ex, q);
        end
        wb(1'b0, 8'hDC, 8'h00);
        chk("status", 8'h00, q);
        power(1'b1, 1'b0);
        // Plain wait request, then wake back to run
        wt <= 1'b1;
        @(posedge clk_i);
        wt <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk_bit("wait request", 1'b1, wm);
        wk <= 1'b1;
        @(posedge clk_i);
        wk <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk_bit("wait left", 1'b0, wm);
        $display("test timer done");
        wb(1'b1, 8'hD8, 8'h07);
        repeat (2) @(posedge clk_i);
        chk_bit("active", 1'b1, act);
        power(1'b0, 1'b1);
        wb(1'b1, 8'hD8, 8'h06);
        wb(1'b0, 8'hD8, 8'h00);
        chk("sticky", 8'h07, q);
        repeat (3) begin
            repeat (200) @(posedge clk_i);
            wb(1'b1, 8'hD8, 8'h07);
        end
        wb(1'b0, 8'hDC, 8'h00);
        chk("status", 8'h00, q);
        wb(1'b1, 8'hD8, 8'h07);
        wait_for(1'b1, 400);
        chk_bit("period", 1'b1, n >= 33 * TICK - 8 && n <= 33 * TICK + 8);
        repeat (3) @(posedge clk_i);
        wait_for(1'b0, 40);
        wb(1'b0, 8'hD8, 8'h00);
        chk("after expiry", 8'hFE, q);
        wb(1'b0, 8'hDC, 8'h00);
        chk("status", 8'h08, q);
        chk_bit("active", 1'b0, act);
        $display("test expiry done");
        wb(1'b1, 8'hDC, 8'h08);
        wb(1'b0, 8'hDC, 8'h00);
        chk("flag clear", 8'h00, q);
        wb(1'b1, 8'hD8, 8'h05);
        repeat (3) @(posedge clk_i);
        wait_for(1'b0, 40);
        wb(1'b0, 8'hDC, 8'h00);
        chk("status", 8'h08, q);
        $display("test software reset done");
        do_reset(1'b1);
        chk_bit("active", 1'b1, act);
        // Longest period, so no expiry during the mode checks that follow
        wb(1'b1, 8'hD8, 8'hFE);
        wb(1'b0, 8'hD8, 8'h00);
        chk("forced on", 8'hFF, q);
        wb(1'b0, 8'hDC, 8'h00);
        chk("status", 8'h04, q);
        power(1'b0, 1'b1);
        $display("test hardware option done");
        stop_test();
    end
endmodule : dwt_top_tb
